/* File: verilog/hdco_top.sv */
// Purpose: Host device code, master terminal, mask bit, rate and block length straps
// Assumes: Straps are static after reset; AXI4-Lite slave for software view
// Notes: Code bit numbering is MSB-first, six bits wide
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "hdco_consts.svh"

module hdco_top #(
  parameter int MASK_WIDTH = `HDCO_MASK_WIDTH
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Strap inputs
  input hdco_pkg::hdco_straps_type straps,
  // Host I/O instruction port
  input wire logic io_strobe,
  input wire logic [5:0] io_device_field,
  input wire logic interrupt_acknowledge_instr,
  input wire logic [MASK_WIDTH-1:0] mask_word_load,
  input wire logic mask_word_strobe,
  // Host I/O results
  output logic mux_select_q,
  output logic master_select_q,
  output logic [5:0] interrupt_acknowledge_instr_code_q,
  output logic interrupt_acknowledge_instr_valid_q,
  output logic int_masked_q,
  output logic [5:0] device_code_q,
  output logic [5:0] pcb_length_q,
  output logic [3:0] port_rate_q,
  output logic port0_master_q,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Elaboration check, mask selector serves sixteen bits only
  if (MASK_WIDTH != 16)
  begin : g_mask_width_check
    $error("hdco_top: MASK_WIDTH must be 16");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Build six-bit code from four straps and the alt select, MSB-first bit numbering
  function automatic logic [5:0] code_of(input logic [3:0] s, input logic alt);
    logic [5:0] c;
    c = 6'h00;
    c[5] = alt;  // Code bit 0
    c[4] = s[3]; // Code bit 1
    c[3] = s[2]; // Code bit 2
    c[2] = s[1]; // Code bit 3
    c[1] = 1'b0; // Code bit 4
    c[0] = s[0]; // Code bit 5
    return c;
  endfunction : code_of

  // Select a mask word bit, position counted from the MSB
  function automatic logic mask_bit_of(input logic [15:0] w, input logic [3:0] pos);
    return w[4'hF - pos];
  endfunction : mask_bit_of

  // Word-aligned register address, byte lanes dropped
  function automatic logic [7:0] word_addr(input logic [7:0] a);
    return {a[7:2], 2'h0};
  endfunction : word_addr

  // ----------------------------------------------------------------
  // Strap capture after reset
  // ----------------------------------------------------------------

  // Strap copy and capture flag
  hdco_pkg::hdco_straps_type straps_q;
  logic captured_q;

  // Latch straps once at release, hold them static
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      captured_q <= 1'b0;
    else
      captured_q <= 1'b1;
  end

  // Straps follow the jumpers through reset, then freeze
  // Freezing keeps a late jumper change from moving the code mid-run
  always_ff @(posedge aclk)
  begin
    if (!captured_q)
      straps_q <= straps;
  end

  // ----------------------------------------------------------------
  // Software control registers
  // ----------------------------------------------------------------

  // Port 0 role, rate selection and host mask word
  logic port0_master_sel_q;
  logic [3:0] rate_sel_q;
  logic [MASK_WIDTH-1:0] mask_word_q;

  // ----------------------------------------------------------------
  // Code decode
  // ----------------------------------------------------------------

  wire logic [5:0] mux_code = code_of(straps_q.device_code_straps,
                                      straps_q.alt_code_select);
  wire logic [5:0] interrupt_acknowledge_instr_code = code_of(straps_q.interrupt_acknowledge_instr_code_straps,
                                       straps_q.alt_code_select);
  wire logic [5:0] master_lo = straps_q.alt_code_select ? `HDCO_ALT_MASTER_LO
                                                        : `HDCO_MASTER_CODE_LO;
  wire logic [5:0] master_hi = straps_q.alt_code_select ? `HDCO_ALT_MASTER_HI
                                                        : `HDCO_MASTER_CODE_HI;
  wire logic mtm_active = straps_q.master_mode_enable & port0_master_sel_q;
  wire logic master_match = (io_device_field == master_lo) | (io_device_field == master_hi);
  wire hdco_pkg::hdco_decode_type dec = '{
    mux_hit: io_strobe && (io_device_field == mux_code),
    master_hit: io_strobe && mtm_active && master_match,
    interrupt_acknowledge_instr_match: interrupt_acknowledge_instr_code == mux_code
  };
  wire logic [5:0] pcb_len =
    (straps_q.pcb_length_sel == hdco_pkg::HDCO_PCB_20) ? `HDCO_PCB_LEN_MID :
    (straps_q.pcb_length_sel == hdco_pkg::HDCO_PCB_10) ? `HDCO_PCB_LEN_SHORT :
                                                          `HDCO_PCB_LEN_DEFAULT;
  wire logic [3:0] eff_rate = (straps_q.high_rate_enable && rate_sel_q == `HDCO_RATE_LOWEST)
                              ? `HDCO_RATE_SUBST : rate_sel_q;
  wire logic mask_bit = mask_bit_of(mask_word_q, straps_q.mask_position);

  // ----------------------------------------------------------------
  // Host-side outputs
  // ----------------------------------------------------------------

  // Mask word load from host
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mask_word_q <= '0;
    else if (mask_word_strobe)
      mask_word_q <= mask_word_load;
  end

  // Registered select and status outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mux_select_q <= 1'b0;
      master_select_q <= 1'b0;
      interrupt_acknowledge_instr_code_q <= 6'h00;
      interrupt_acknowledge_instr_valid_q <= 1'b0;
      int_masked_q <= 1'b0;
      device_code_q <= 6'h00;
      pcb_length_q <= 6'h00;
      port_rate_q <= 4'h0;
      port0_master_q <= 1'b0;
    end
    else
    begin
      mux_select_q <= dec.mux_hit;
      master_select_q <= dec.master_hit;
      interrupt_acknowledge_instr_code_q <= interrupt_acknowledge_instr_code;
      interrupt_acknowledge_instr_valid_q <= interrupt_acknowledge_instr;
      int_masked_q <= mask_bit;
      device_code_q <= mux_code;
      pcb_length_q <= pcb_len;
      port_rate_q <= eff_rate;
      port0_master_q <= mtm_active;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------

  // Captured write halves
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // Write handshake decode
  wire logic aw_fire = s_axi_awvalid & s_axi_awready;
  wire logic w_fire = s_axi_wvalid & s_axi_wready;
  wire logic wr_do = aw_got_q & w_got_q & ~s_axi_bvalid;
  wire logic wr_ctrl = wr_do & (awaddr_q == `HDCO_REG_CTRL) & wstrb_q[0];
  wire logic wr_rate = wr_do & (awaddr_q == `HDCO_REG_RATE) & wstrb_q[0];
  wire logic wr_ok = (awaddr_q == `HDCO_REG_CTRL) | (awaddr_q == `HDCO_REG_RATE);

  // Write address and data capture in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `HDCO_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_got_q & ~aw_fire;
      s_axi_wready <= ~w_got_q & ~w_fire;
      if (aw_fire)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= word_addr(s_axi_awaddr);
      end
      if (w_fire)
      begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_do)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `HDCO_RESP_OKAY : `HDCO_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
      end
    end
  end

  // Writable control fields
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port0_master_sel_q <= 1'b1;
      rate_sel_q <= 4'h0;
    end
    else
    begin
      if (wr_ctrl)
        port0_master_sel_q <= wdata_q[`HDCO_CTRL_PORT0_MTM];
      if (wr_rate)
        rate_sel_q <= wdata_q[3:0];
    end
  end

  // Read data mux
  wire logic [7:0] ar_addr = word_addr(s_axi_araddr);
  // Control view, read-only straps around the one writable bit
  wire logic [31:0] ctrl_view = {
    28'h0,
    straps_q.alt_code_select, // Bit 3
    straps_q.high_rate_enable, // Bit 2
    port0_master_sel_q, // Bit 1
    straps_q.master_mode_enable // Bit 0
  };
  // Code view, both codes side by side so software sees they agree
  wire logic [31:0] code_view = {
    6'h00,
    pcb_len, // Bits 25:20
    straps_q.mask_position, // Bits 19:16
    dec.interrupt_acknowledge_instr_match, // Bit 15
    1'b0,
    interrupt_acknowledge_instr_code, // Bits 13:8
    2'h0,
    mux_code // Bits 5:0
  };
  wire logic [31:0] rate_view = {24'h0, eff_rate, rate_sel_q};
  // Status view
  wire logic [31:0] stat_view = {
    29'h0,
    mtm_active, // Bit 2
    int_masked_q, // Bit 1
    captured_q // Bit 0
  };
  wire logic rd_hit = (ar_addr == `HDCO_REG_CTRL) | (ar_addr == `HDCO_REG_CODE) |
                      (ar_addr == `HDCO_REG_RATE) | (ar_addr == `HDCO_REG_STATUS);
  wire logic [31:0] rd_data = (ar_addr == `HDCO_REG_CTRL) ? ctrl_view :
                              (ar_addr == `HDCO_REG_CODE) ? code_view :
                              (ar_addr == `HDCO_REG_RATE) ? rate_view :
                              (ar_addr == `HDCO_REG_STATUS) ? stat_view : 32'h0000_0000;

  // Read channel, one read in flight
  // Ready stays low while the answer stands
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `HDCO_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_hit ? `HDCO_RESP_OKAY : `HDCO_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule : hdco_top

/* File: verilog/hdco_consts.svh */
// Purpose: Constants for the host device code and option strap block
// Assumes: Codes are octal-derived six-bit values, bit 0 is the MSB of the code
// Notes: Register offsets are byte addresses on the AXI4-Lite slave
`ifndef HDCO_CONSTS_SVH
`define HDCO_CONSTS_SVH

// Device codes
`define HDCO_DEFAULT_CODE 6'h15
`define HDCO_MASTER_CODE_LO 6'h08
`define HDCO_MASTER_CODE_HI 6'h09
`define HDCO_ALT_MUX_CODE 6'h25
`define HDCO_ALT_MASTER_LO 6'h28
`define HDCO_ALT_MASTER_HI 6'h29
// Default strap word, code bits 1,3,5 (MSB-first numbering)
`define HDCO_DEFAULT_STRAPS 4'hB

// Mask bit position, MSB-first numbering
`define HDCO_DEFAULT_MASK_POS 4'h5
`define HDCO_MASK_WIDTH 16

// Control block lengths in words
`define HDCO_PCB_LEN_DEFAULT 6'h20
`define HDCO_PCB_LEN_MID 6'h10
`define HDCO_PCB_LEN_SHORT 6'h08

// Rate selections
`define HDCO_RATE_LOWEST 4'h0
`define HDCO_RATE_SUBST 4'hF

// Register byte offsets
`define HDCO_REG_CTRL 8'h00
`define HDCO_REG_CODE 8'h04
`define HDCO_REG_RATE 8'h08
`define HDCO_REG_STATUS 8'h0C
`define HDCO_REG_IOCMD 8'h10

// Field positions in CTRL
`define HDCO_CTRL_MTM_EN 0
`define HDCO_CTRL_PORT0_MTM 1
`define HDCO_CTRL_HIRATE 2
`define HDCO_CTRL_ALT 3

// AXI responses
`define HDCO_RESP_OKAY 2'h0
`define HDCO_RESP_SLVERR 2'h2

`endif

/* File: verilog/hdco_pkg.sv */
// Purpose: Types for the host device code and option strap block
// Assumes: Constants come from hdco_consts.svh
// Notes: Straps travel as one packed struct
package hdco_pkg;

  // Pcb length selection
  typedef enum logic [1:0] {
    HDCO_PCB_40 = 2'h0,
    HDCO_PCB_20 = 2'h1,
    HDCO_PCB_10 = 2'h2
  } hdco_pcb_sel_type;

  // Strap inputs as read from jumpers
  typedef struct packed {
    logic [3:0] device_code_straps;
    logic [3:0] interrupt_acknowledge_instr_code_straps;
    logic master_mode_enable;
    logic alt_code_select;
    logic high_rate_enable;
    logic [3:0] mask_position;
    hdco_pcb_sel_type pcb_length_sel;
  } hdco_straps_type;

  // Host I/O instruction decode result
  typedef struct packed {
    logic mux_hit;
    logic master_hit;
    logic interrupt_acknowledge_instr_match;
  } hdco_decode_type;

endpackage : hdco_pkg

/* File: tb/hdco_properties.sv */
// Purpose: Port checks for the strap block
// Assumes: Straps change only while reset is low
// Notes: Bound to hdco_top in the bench file
`timescale 1ns/1ps
module hdco_properties #(
  parameter int MASK_WIDTH = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Straps and host side
  input hdco_pkg::hdco_straps_type straps,
  input wire logic io_strobe,
  input wire logic [5:0] io_device_field,
  input wire logic [MASK_WIDTH-1:0] mask_word_load,
  input wire logic mask_word_strobe,
  // Results
  input wire logic mux_select_q,
  input wire logic master_select_q,
  input wire logic [5:0] interrupt_acknowledge_instr_code_q,
  input wire logic interrupt_acknowledge_instr_valid_q,
  input wire logic int_masked_q,
  input wire logic [5:0] device_code_q,
  input wire logic [5:0] pcb_length_q
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Upper five field bits, for the code pair test
  wire [4:0] fld_hi = io_device_field[5:1];
  property p_mux_hit;
    io_strobe && io_device_field == device_code_q |=> mux_select_q;
  endproperty
  a_mux_hit: assert property (p_mux_hit) else $error("mux hit lost");
  property p_mux_miss;
    io_strobe && io_device_field != device_code_q |=> !mux_select_q;
  endproperty
  a_mux_miss: assert property (p_mux_miss) else $error("mux miss");
  property p_master_code;
    master_select_q |-> $past(io_strobe) && $past(fld_hi) == {device_code_q[5], 4'h4};
  endproperty
  a_master_code: assert property (p_master_code) else $error("master code");
  property p_master_off;
    !straps.master_mode_enable |-> !master_select_q;
  endproperty
  a_master_off: assert property (p_master_off) else $error("master off");
  property p_bit4_zero;
    device_code_q[1] == 1'b0;
  endproperty
  a_bit4_zero: assert property (p_bit4_zero) else $error("code bit 4");
  property p_interrupt_acknowledge_instr_match;
    interrupt_acknowledge_instr_valid_q |-> interrupt_acknowledge_instr_code_q == device_code_q;
  endproperty
  a_interrupt_acknowledge_instr_match: assert property (p_interrupt_acknowledge_instr_match) else $error("interrupt_acknowledge_instr code");
  property p_mask;
    mask_word_strobe |-> ##2 int_masked_q == mask_word_load[15 - straps.mask_position];
  endproperty
  a_mask: assert property (p_mask) else $error("mask bit");
  property p_pcb;
    pcb_length_q != 6'h00 |-> pcb_length_q == (straps.pcb_length_sel == 2'h0 ? 6'h20 :
      straps.pcb_length_sel == 2'h1 ? 6'h10 : 6'h08);
  endproperty
  a_pcb: assert property (p_pcb) else $error("block length");
endmodule : hdco_properties

/* File: tb/hdco_host_model.sv */
// Purpose: Host I/O bus model issuing instructions
// Assumes: One instruction per cycle, requested by the bench
// Notes: Idle field is inverted each cycle so stale codes never linger
`timescale 1ns/1ps
module hdco_host_model (
  // Clock
  input wire logic aclk,
  // Requests
  input wire logic cmd_valid,
  input wire logic [5:0] cmd_field,
  input wire logic cmd_interrupt_acknowledge_instr,
  // Host I/O bus
  output logic io_strobe = 1'b0,
  output logic [5:0] io_device_field = 6'h00,
  output logic interrupt_acknowledge_instr = 1'b0
);
  // Launch instruction, scramble idle field
  always @(posedge aclk)
  begin
    io_strobe <= cmd_valid;
    io_device_field <= cmd_valid ? cmd_field : ~io_device_field;
    interrupt_acknowledge_instr <= cmd_valid & cmd_interrupt_acknowledge_instr;
  end
endmodule : hdco_host_model

/* File: tb/hdco_top_bench.sv */
// Purpose: Self-checking bench for hdco_top
// Assumes: Straps change only while reset is low
// Notes: Four strap sets with I/O, mask and register traffic
`timescale 1ns/1ps
module hdco_top_bench;
  logic aclk = 1'b0, aresetn = 1'b0, cmd_valid = 1'b0, cmd_interrupt_acknowledge_instr = 1'b0, st_d = 1'b0;
  hdco_pkg::hdco_straps_type straps = '0;
  logic [5:0] cmd_field = 6'h00, code, f, io_device_field, interrupt_acknowledge_instr_code_q, device_code_q;
  logic [15:0] mask_word_load = 16'h0000;
  logic mask_word_strobe = 1'b0, mtm, p0m, io_strobe, interrupt_acknowledge_instr;
  logic mux_select_q, master_select_q, interrupt_acknowledge_instr_valid_q, int_masked_q, port0_master_q;
  logic [5:0] pcb_length_q;
  logic [3:0] port_rate_q;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, seed = 32'd49239;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [2:0] expq[$];
  int mismatches = 0, n_compared = 0, c, k;
  // Strap sets: code straps, mask position, block length select
  logic [3:0] cs [4] = '{4'hB, 4'h3, 4'h2, 4'hF};
  logic [3:0] ps [4] = '{4'h5, 4'h0, 4'hF, 4'h9};
  logic [1:0] pc [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  logic [5:0] pl [3] = '{6'h20, 6'h10, 6'h08};
  logic [3:0] al = 4'h2, mt = 4'hB, hr = 4'h1;

  always #25 aclk = ~aclk;

  hdco_top u_hdco_top (.aclk, .aresetn, .straps, .io_strobe, .io_device_field,
    .interrupt_acknowledge_instr, .mask_word_load, .mask_word_strobe, .mux_select_q,
    .master_select_q, .interrupt_acknowledge_instr_code_q, .interrupt_acknowledge_instr_valid_q, .int_masked_q, .device_code_q,
    .pcb_length_q, .port_rate_q, .port0_master_q, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  hdco_host_model u_hdco_host_model (.aclk, .cmd_valid, .cmd_field, .cmd_interrupt_acknowledge_instr, .io_strobe,
    .io_device_field, .interrupt_acknowledge_instr);

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // Write: address and data together, wait for the response
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    while (!s_axi_bvalid) @(posedge aclk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr

  // Read one word
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd

  // One host instruction, expected selects noted
  task automatic io(input logic [5:0] fv, input logic i);
    cmd_valid <= 1'b1;
    cmd_field <= fv;
    cmd_interrupt_acknowledge_instr <= i;
    expq.push_back({fv == code, mtm & p0m & (fv[5:1] == {code[5], 4'h4}), i});
    @(posedge aclk);
  endtask : io

  // Compare selects the cycle after each instruction
  always @(posedge aclk) st_d <= io_strobe;
  always @(negedge aclk)
    if (st_d === 1'b1 && expq.size() > 0)
      cmp("selects", expq.pop_front(), {mux_select_q, master_select_q, interrupt_acknowledge_instr_valid_q});

  // Watchdog, far beyond the few hundred cycles needed
  initial
  begin
    #(5000 * 50);
    mismatches++;
    stop_test();
  end

  initial
  begin
    for (c = 0; c < 4; c++)
    begin
      code = {al[c], cs[c][3:1], 1'b0, cs[c][0]};
      mtm = mt[c];
      p0m = 1'b1;
      aresetn <= 1'b0;
      straps <= '{cs[c], cs[c], mt[c], al[c], hr[c], ps[c], hdco_pkg::hdco_pcb_sel_type'(pc[c])};
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      cmp("code", code, device_code_q);
      cmp("interrupt_acknowledge_instr_code", code, interrupt_acknowledge_instr_code_q);
      cmp("pcb_len", pl[pc[c]], pcb_length_q);
      cmp("port0", mt[c], port0_master_q);
      for (k = 0; k < 6; k++)
      begin
        seed = xs(seed);
        f = k == 0 ? code : k < 3 ? {code[5], 4'h4, k[0]} : seed[5:0];
        io(f, seed[8]);
      end
      cmd_valid <= 1'b0;
      seed = xs(seed);
      mask_word_load <= seed[15:0];
      mask_word_strobe <= 1'b1;
      @(posedge aclk);
      mask_word_strobe <= 1'b0;
      repeat (3) @(posedge aclk);
      cmp("mask", seed[15 - ps[c]], int_masked_q);
      axi_rd(8'h04, d, r);
      cmp("code_reg", {code, code}, {d[13:8], d[5:0]});
      axi_rd(8'h20, d, r);
      cmp("rd_resp", 2'h2, r);
      cmp("rd_data", 32'h0, d);
      axi_wr(8'h04, seed, r);
      cmp("wr_resp", 2'h2, r);
      // Random rate, then a write with byte lane 0 off that must not land
      axi_wr(8'h08, {28'h0, seed[19:16]}, r);
      cmp("wr_resp", 2'h0, r);
      s_axi_wstrb <= 4'hE;
      axi_wr(8'h08, 32'h0, r);
      s_axi_wstrb <= 4'hF;
      repeat (2) @(posedge aclk);
      cmp("rate", (hr[c] && seed[19:16] == 4'h0) ? 4'hF : seed[19:16], port_rate_q);
      axi_wr(8'h08, 32'h0, r);
      repeat (2) @(posedge aclk);
      cmp("rate", hr[c] ? 4'hF : 4'h0, port_rate_q);
      axi_wr(8'h00, 32'h0, r);
      cmp("wr_resp", 2'h0, r);
      cmp("port0", 1'b0, port0_master_q);
      p0m = 1'b0;
      io({code[5], 5'h08}, 1'b0);
      io(code, 1'b1);
      cmd_valid <= 1'b0;
      repeat (3) @(posedge aclk);
    end
    stop_test();
  end
endmodule : hdco_top_bench

bind hdco_top hdco_properties #(.MASK_WIDTH(MASK_WIDTH)) u_hdco_properties (.aclk, .aresetn,
  .straps, .io_strobe, .io_device_field, .mask_word_load, .mask_word_strobe, .mux_select_q,
  .master_select_q, .interrupt_acknowledge_instr_code_q, .interrupt_acknowledge_instr_valid_q, .int_masked_q, .device_code_q,
  .pcb_length_q);
